//--- src/sadc_pkg.sv
// Purpose: Constants and types for the SAR converter control block
// Assumes: 100 MHz ref_clk
// Notes: Timing counts are in ref_clk cycles
package sadc_pkg;
    localparam int REF_CLK_HZ = 100_000_000;
    localparam int RESULT_W = 8;
    localparam int OSC_HZ = 400_000;
    localparam int OSC_DIV = REF_CLK_HZ / OSC_HZ;
    localparam int OSC_CNT_W = 8;
    localparam logic [OSC_CNT_W-1:0] OSC_LAST = 8'(OSC_DIV - 1);
    // Conversion takes RESULT_W oscillator periods plus one settle step
    localparam int CONV_STEPS = RESULT_W + 1;
    localparam int CONV_MAX_US = 35;
    localparam int CONV_MAX_CYC = CONV_MAX_US * (REF_CLK_HZ / 1_000_000);
    localparam int STROBE_MIN_NS = 1000;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0] RESULT_ZERO = 8'h00;
    localparam logic [7:0] RESULT_ONES = 8'hFF;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [3:0] BIT_CNT_LAST = 4'h8;
    typedef enum logic [2:0] {
        SADC_IDLE = 3'b000,
        SADC_ARMED = 3'b001,
        SADC_CONV = 3'b011,
        SADC_READ = 3'b010,
        SADC_DONE = 3'b110
    } sadc_state_t;
endpackage

//--- src/sadc_osc_if.sv
// Purpose: Carrier between control and internal oscillator
// Assumes: Same clock domain
// Notes: Tick is one ref_clk pulse per oscillator period
`timescale 1ns/100ps
`default_nettype none
interface sadc_osc_if;
    logic run;
    logic tick;
    modport ctrl (output run, input tick);
    modport osc (input run, output tick);
endinterface
`default_nettype wire

//--- src/sadc_osc.sv
// Purpose: Internal 400 kHz step oscillator
// Assumes: ref_clk at 100 MHz
// Notes: Counts freely while run is high
`timescale 1ns/100ps
`default_nettype none
module sadc_osc
    import sadc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    sadc_osc_if.osc osc
);
    logic [OSC_CNT_W-1:0] cnt_q;
    logic tick_q;

    // Divider held at zero while run is low, independent of the shift clock
    always_ff @(posedge ref_clk) begin
        if (srst || !osc.run) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (cnt_q == OSC_LAST);
            cnt_q <= (cnt_q == OSC_LAST) ? '0 : cnt_q + 8'h01;
        end
    end
    assign osc.tick = tick_q;
endmodule
`default_nettype wire

//--- src/sadc_ctrl.sv
// Purpose: Conversion control and 3-wire serial readout of an 8-bit SAR converter
// Assumes: Pins are asynchronous to ref_clk; analog sample arrives as a digital word
// Notes: Shift clock edges found by sampling
`timescale 1ns/100ps
`default_nettype none
module sadc_ctrl
    import sadc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic conversion_start_strobe,
    input wire logic shift_clock,
    input wire logic shutdown_n,
    input wire logic [8:0] sample_code,
    input wire logic sample_negative,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic tracking,
    output logic low_power
);
    sadc_osc_if osc_bus ();
    sadc_osc i_sadc_osc (
        .ref_clk(ref_clk),
        .srst(srst),
        .osc(osc_bus)
    );

    logic [1:0] cs_sync_q, sc_sync_q, sd_sync_q;
    logic cs_prev_q, sc_prev_q;
    logic cs_s, sc_s, sd_s, cs_fall, cs_rise, sc_fall;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cs_sync_q <= 2'h0;
            sc_sync_q <= 2'h0;
            sd_sync_q <= 2'h3;
            cs_prev_q <= 1'b0;
            sc_prev_q <= 1'b0;
        end else begin
            cs_sync_q <= {cs_sync_q[0], conversion_start_strobe};
            sc_sync_q <= {sc_sync_q[0], shift_clock};
            sd_sync_q <= {sd_sync_q[0], shutdown_n};
            cs_prev_q <= cs_sync_q[1];
            sc_prev_q <= sc_sync_q[1];
        end
    end
    assign cs_s = cs_sync_q[1];
    assign sc_s = sc_sync_q[1];
    assign sd_s = sd_sync_q[1];
    assign cs_fall = cs_prev_q && !cs_s;
    assign cs_rise = !cs_prev_q && cs_s;
    assign sc_fall = sc_prev_q && !sc_s;

    sadc_state_t state_q;
    logic [3:0] step_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] held_q, result_q, shift_q;
    logic aborted_q;
    logic conv_end;

    assign osc_bus.run = (state_q == SADC_CONV);
    assign conv_end = (state_q == SADC_CONV) && osc_bus.tick && (step_q == 4'(CONV_STEPS - 1));

    // Clamped straight binary code of the held sample
    function automatic logic [7:0] code_of(input logic neg, input logic [8:0] raw);
        logic [7:0] c;
        c = RESULT_ZERO;
        if (neg) begin
            c = RESULT_ZERO;
        end else if (raw[8]) begin
            c = RESULT_ONES;
        end else begin
            c = raw[7:0];
        end
        return c;
    endfunction

    // Main sequence
    always_ff @(posedge ref_clk) begin
        if (srst || !sd_s) begin
            state_q <= SADC_IDLE;
        end else begin
            case (state_q)
                SADC_IDLE: if (cs_rise) state_q <= SADC_ARMED;
                SADC_ARMED: if (cs_fall) state_q <= SADC_CONV;
                SADC_CONV: if (conv_end) state_q <= SADC_READ;
                SADC_READ: if (sc_fall && !cs_s && bit_cnt_q == 4'(RESULT_W - 1)) begin
                    state_q <= SADC_DONE;
                end
                SADC_DONE: state_q <= SADC_IDLE;
                default: state_q <= SADC_IDLE;
            endcase
        end
    end

    // Oscillator step counter
    always_ff @(posedge ref_clk) begin
        if (srst || state_q != SADC_CONV) begin
            step_q <= 4'h0;
        end else if (osc_bus.tick) begin
            step_q <= step_q + 4'h1;
        end
    end

    // Sample hold and successive approximation register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            held_q <= RESULT_ZERO;
            result_q <= RESULT_ZERO;
        end else if (state_q == SADC_ARMED && cs_fall) begin
            held_q <= code_of(sample_negative, sample_code);
            result_q <= RESULT_ZERO;
        end else if (state_q == SADC_CONV && osc_bus.tick && step_q < 4'(RESULT_W)) begin
            result_q[3'(RESULT_W - 1) - step_q[2:0]] <= held_q[3'(RESULT_W - 1) - step_q[2:0]];
        end
    end

    // Output shift register and bit counter
    always_ff @(posedge ref_clk) begin
        if (srst || !sd_s) begin
            shift_q <= RESULT_ZERO;
            bit_cnt_q <= BIT_CNT_RST;
        end else if (conv_end) begin
            shift_q <= result_q;
            bit_cnt_q <= BIT_CNT_RST;
        end else if (state_q == SADC_READ && sc_fall && !cs_s) begin
            shift_q <= {shift_q[6:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // Shutdown abort memory; cleared by eight shift clocks once shutdown_n is high, in any state
    logic [3:0] clr_cnt_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aborted_q <= 1'b0;
            clr_cnt_q <= 4'h0;
        end else if (!sd_s && (state_q == SADC_CONV || state_q == SADC_ARMED)) begin
            aborted_q <= 1'b1;
            clr_cnt_q <= 4'h0;
        end else if (aborted_q && sd_s && sc_fall) begin
            clr_cnt_q <= clr_cnt_q + 4'h1;
            if (clr_cnt_q == 4'(RESULT_W - 1)) begin
                aborted_q <= 1'b0;
            end
        end
    end

    // Pin drive
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            serial_data_out <= 1'b0;
            serial_data_oe <= 1'b0;
        end else if (!sd_s) begin
            serial_data_out <= 1'b0;
            serial_data_oe <= 1'b0;
        end else if (state_q == SADC_CONV && !conv_end) begin
            serial_data_out <= 1'b0;
            serial_data_oe <= 1'b1;
        end else if (conv_end) begin
            serial_data_out <= result_q[7];
            serial_data_oe <= 1'b1;
        end else if (state_q == SADC_READ) begin
            if (sc_fall && !cs_s && bit_cnt_q == 4'(RESULT_W - 1)) begin
                serial_data_oe <= 1'b0;
                serial_data_out <= 1'b0;
            end else if (sc_fall && !cs_s) begin
                serial_data_out <= shift_q[6];
                serial_data_oe <= 1'b1;
            end
        end else begin
            serial_data_out <= 1'b0;
            serial_data_oe <= 1'b0;
        end
    end

    assign tracking = (state_q != SADC_CONV);
    assign low_power = !sd_s;

    // Cycle counter from strobe fall to result
    int unsigned conv_cyc_q;
    always_ff @(posedge ref_clk) begin
        if (srst || state_q != SADC_CONV) conv_cyc_q <= 0;
        else conv_cyc_q <= conv_cyc_q + 1;
    end

    AST_CONV_BOUND: assert property (@(posedge ref_clk) disable iff (srst)
        conv_cyc_q <= CONV_MAX_CYC) else $error("conversion too long");
    AST_START_ON_FALL: assert property (@(posedge ref_clk) disable iff (srst || !sd_s)
        state_q == SADC_ARMED && cs_fall |=> state_q == SADC_CONV)
        else $error("strobe fall did not start conversion");
    AST_LOW_DURING_CONV: assert property (@(posedge ref_clk) disable iff (srst || !sd_s)
        state_q == SADC_CONV && $past(state_q) == SADC_CONV |-> serial_data_oe && !serial_data_out)
        else $error("output not low during conversion");
    AST_MSB_FIRST: assert property (@(posedge ref_clk) disable iff (srst || !sd_s)
        conv_end |=> serial_data_oe && serial_data_out == $past(result_q[7]))
        else $error("msb not presented");
    AST_HIZ_SHUTDOWN: assert property (@(posedge ref_clk) disable iff (srst)
        !sd_s |=> !serial_data_oe && state_q == SADC_IDLE)
        else $error("output driven in shutdown");
    AST_NO_SHIFT_STROBE_HIGH: assert property (@(posedge ref_clk) disable iff (srst || !sd_s)
        state_q == SADC_READ && cs_s |=> $stable(bit_cnt_q))
        else $error("shift while strobe high");
    AST_RELEASE_EIGHTH: assert property (@(posedge ref_clk) disable iff (srst || !sd_s)
        state_q == SADC_READ && sc_fall && !cs_s && bit_cnt_q == 4'h7
        |=> !serial_data_oe ##1 state_q == SADC_IDLE)
        else $error("not released at eighth fall");
    AST_IDLE_NEEDS_RISE: assert property (@(posedge ref_clk) disable iff (srst || !sd_s)
        state_q == SADC_IDLE && !cs_rise |=> state_q == SADC_IDLE)
        else $error("left idle without strobe rise");
    AST_EXTRA_CLOCKS_HIZ: assert property (@(posedge ref_clk) disable iff (srst)
        state_q == SADC_IDLE && $past(state_q) == SADC_IDLE |-> !serial_data_oe)
        else $error("driven after readout");
    AST_TRACK: assert property (@(posedge ref_clk) disable iff (srst || !sd_s)
        conv_end |=> tracking) else $error("track not resumed");

    COV_CONV: cover property (@(posedge ref_clk) disable iff (srst) conv_end);
    COV_READOUT: cover property (@(posedge ref_clk) disable iff (srst) state_q == SADC_DONE);
    COV_ABORT: cover property (@(posedge ref_clk) disable iff (srst)
        state_q == SADC_CONV ##1 !sd_s);
    COV_ABORT_CLEAR: cover property (@(posedge ref_clk) disable iff (srst)
        aborted_q ##1 !aborted_q);
    COV_PAUSE: cover property (@(posedge ref_clk) disable iff (srst)
        state_q == SADC_READ && cs_s && sc_fall);
endmodule
`default_nettype wire

//--- dv/sadc_host.sv
// Purpose: Host model driving strobe and shift clock and reading the result
// Assumes: Mode 0 reader, shift clock made from its own delays
// Notes: Publishes one 11-bit word per conversion on rx_valid
`timescale 1ns/100ps
`default_nettype none
module sadc_host (
    input wire logic ref_clk,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    input wire logic tracking,
    output logic conversion_start_strobe,
    output logic shift_clock,
    output logic rx_valid,
    output logic [10:0] rx_word
);
    initial begin
        conversion_start_strobe = 1'b0;
        shift_clock = 1'b0;
        rx_valid = 1'b0;
        rx_word = '0;
    end
    // Shift clock pulses, idle low
    task automatic clocks(input int n);
        // Offset keeps shift clock edges clear of ref_clk edges
        #1;
        repeat (n) begin
            #62.5 shift_clock = 1'b1;
            #62.5 shift_clock = 1'b0;
        end
    endtask
    // Strobe pulse, optional shift clocks while high
    task automatic fire(input int n_high, input int n_clk);
        @(negedge ref_clk);
        conversion_start_strobe = 1'b1;
        fork
            clocks(n_clk);
            repeat (n_high) @(negedge ref_clk);
        join
        conversion_start_strobe = 1'b0;
    endtask
    // Wait out the conversion, read eight bits, then extra clocks
    // Pause raises the strobe around one shift clock mid-readout
    task automatic readout(input bit pause);
        logic [10:0] w;
        w = '0;
        repeat (1000) @(negedge ref_clk);
        w[10] = (serial_data_out === 1'b0) && (serial_data_oe === 1'b1) && (tracking === 1'b0);
        repeat (2500) @(posedge ref_clk);
        #1 w[9] = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            if (pause && i == 3) begin
                #97.5 conversion_start_strobe = 1'b1;
                clocks(1);
                #100 conversion_start_strobe = 1'b0;
            end
            #62.5 shift_clock = 1'b1;
            w[i] = serial_data_out;
            w[9] = w[9] & (serial_data_oe === 1'b1);
            #62.5 shift_clock = 1'b0;
        end
        #100 w[8] = (serial_data_oe === 1'b0);
        clocks(2);
        #100 w[8] = w[8] & (serial_data_oe === 1'b0) & (tracking === 1'b1);
        @(negedge ref_clk);
        rx_word = w;
        rx_valid = 1'b1;
        @(negedge ref_clk);
        rx_valid = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- dv/sadc_ctrl_bench.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Host model drives the serial side
// Notes: Expected words queued by the driver, popped by the monitor
`timescale 1ns/100ps
`default_nettype none
module sadc_ctrl_bench;
    import sadc_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic shutdown_n = 1'b1;
    logic [8:0] sample_code = 9'h000;
    logic sample_negative = 1'b0;
    logic strobe, sclk, sdo, oe, tracking, low_power, rx_valid;
    logic [10:0] rx_word;
    logic [10:0] expq[$];
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 ref_clk = ~ref_clk;
    sadc_ctrl i_sadc_ctrl (.ref_clk(ref_clk), .srst(srst), .conversion_start_strobe(strobe),
        .shift_clock(sclk), .shutdown_n(shutdown_n), .sample_code(sample_code),
        .sample_negative(sample_negative), .serial_data_out(sdo), .serial_data_oe(oe),
        .tracking(tracking), .low_power(low_power));
    sadc_host i_sadc_host (.ref_clk(ref_clk), .serial_data_out(sdo), .serial_data_oe(oe),
        .tracking(tracking), .conversion_start_strobe(strobe), .shift_clock(sclk),
        .rx_valid(rx_valid), .rx_word(rx_word));
    task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            conclude();
        end
    end
    // Monitor: compare each published word with the oldest note
    always @(posedge ref_clk) begin
        if (rx_valid === 1'b1) begin
            if (expq.size() == 0) check("unexpected_word", 11'h000, 11'h7ff);
            else check("rx_word", rx_word, expq.pop_front());
        end
    end
    // One conversion; inputs changed after the strobe fall; early clocks also pause readout
    task automatic convert(input logic [8:0] code, input logic neg, input int n_early);
        @(negedge ref_clk);
        sample_code = code;
        sample_negative = neg;
        expq.push_back({3'b111, neg ? RESULT_ZERO : (code[8] ? RESULT_ONES : code[7:0])});
        i_sadc_host.fire(100, n_early);
        repeat (10) @(negedge ref_clk);
        sample_code = ~code;
        sample_negative = ~neg;
        i_sadc_host.readout(n_early > 0);
    endtask
    initial begin
        void'($urandom(32'hc2df_14c3));
        repeat (10) @(negedge ref_clk);
        srst = 1'b0;
        repeat (200) @(negedge ref_clk);
        check("oe_power_up", 11'(oe), 11'h000);
        check("tracking_idle", 11'(tracking), 11'h001);
        convert(9'h0a5, 1'b1, 0);
        convert(9'h123, 1'b0, 3);
        convert(9'h0ff, 1'b0, 0);
        convert(9'h080, 1'b0, 0);
        for (int i = 0; i < 3; i++) convert(9'($urandom_range(0, 511)), 1'b0, 0);
        i_sadc_host.fire(100, 0);
        repeat (500) @(negedge ref_clk);
        shutdown_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        check("oe_shutdown", 11'(oe), 11'h000);
        check("low_power_on", 11'(low_power), 11'h001);
        shutdown_n = 1'b1;
        repeat (3500) @(negedge ref_clk);
        i_sadc_host.clocks(8);
        @(negedge ref_clk);
        check("low_power_off", 11'(low_power), 11'h000);
        check("oe_cleared", 11'(oe), 11'h000);
        convert(9'($urandom_range(0, 255)), 1'b0, 0);
        repeat (20) @(negedge ref_clk);
        check("pending_words", 11'(expq.size()), 11'h000);
        conclude();
    end
endmodule
`default_nettype wire
